// file: spg_pulse_gen.sv
`timescale 1ns/10ps
`include "spg_params.svh"
module spg_pulse_gen
    import spg_pkg::*;
#(
    parameter int unsigned PULSE_CYC = `SPG_PULSE_CYC
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pps_in,
    input wire logic locked_in,
    input wire logic [31:0] utc_date_in,
    input wire logic [16:0] utc_sod_in,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [31:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic pulse_out_q
);
    // ---------------------------------------------------------------
    // input synchronisers
    // ---------------------------------------------------------------
    logic pps_s1_q, pps_s2_q, pps_s3_q;
    logic lock_s1_q, lock_s2_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pps_s1_q <= 1'b0;
            pps_s2_q <= 1'b0;
            pps_s3_q <= 1'b0;
            lock_s1_q <= 1'b0;
            lock_s2_q <= 1'b0;
        end else begin
            pps_s1_q <= pps_in;
            pps_s2_q <= pps_s1_q;
            pps_s3_q <= pps_s2_q;
            lock_s1_q <= locked_in;
            lock_s2_q <= lock_s1_q;
        end
    end
    wire sec_tick = pps_s2_q && !pps_s3_q;

    // ---------------------------------------------------------------
    // register file
    // ---------------------------------------------------------------
    spg_cfg_if cfg ();
    logic [31:0] date_q, time_q;
    logic mode_q, edge_q;
    logic [24:0] period_q;
    logic [15:0] tz_q;
    logic aw_hold_q, w_hold_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_ok, wr_go;

    function automatic logic [31:0] spg_merge(input logic [31:0] old,
            input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    wire [31:0] wd = spg_merge(32'h00000000, w_data_q, 4'hF);
    wire [11:0] wd_year = wd[27:16];
    wire [24:0] wd_per = wd[24:0];
    assign wr_go = aw_hold_q && w_hold_q && !bvalid;

    always_comb begin
        wr_ok = 1'b1;
        if (aw_addr_q == `SPG_ADDR_DATE) begin
            wr_ok = wd_year >= `SPG_YEAR_MIN && wd_year <= `SPG_YEAR_MAX
                && wd[15:8] >= 8'h01 && wd[15:8] <= 8'h0C
                && wd[7:0] >= 8'h01 && wd[7:0] <= 8'h1F;
        end else if (aw_addr_q == `SPG_ADDR_TIME) begin
            wr_ok = wd[20:16] <= `SPG_HOUR_MAX && wd[13:8] <= `SPG_MIN_MAX
                && wd[5:0] <= `SPG_MIN_MAX;
        end else if (aw_addr_q == `SPG_ADDR_PERIOD) begin
            wr_ok = wd_per >= `SPG_PERIOD_MIN
                && wd_per <= `SPG_PERIOD_MAX;
        end else if (aw_addr_q == `SPG_ADDR_TZONE) begin
            wr_ok = wd[12:8] <= `SPG_TZ_HOUR_LIM
                && wd[5:0] <= `SPG_TZ_MIN_LIM;
        end else if (aw_addr_q == `SPG_ADDR_MODE
                || aw_addr_q == `SPG_ADDR_EDGE) begin
            wr_ok = 1'b1;
        end else begin
            wr_ok = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            bvalid <= 1'b0;
            bresp <= 2'h0;
        end else begin
            if (awvalid && awready) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= {awaddr[7:2], 2'b00};
            end
            if (wvalid && wready) begin
                w_hold_q <= 1'b1;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            if (wr_go) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_ok ? 2'h0 : 2'h2;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end
    assign awready = !aw_hold_q && !bvalid;
    assign wready = !w_hold_q && !bvalid;

    // settings; preset on reset, held for as long as power stays
    wire do_wr = wr_go && wr_ok;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            date_q <= `SPG_RST_DATE;
            time_q <= `SPG_RST_TIME;
            mode_q <= 1'b0;
            period_q <= `SPG_RST_PERIOD;
            edge_q <= 1'b0;
            tz_q <= 16'h0000;
        end else if (do_wr) begin
            if (aw_addr_q == `SPG_ADDR_DATE) begin
                date_q <= spg_merge(date_q, w_data_q, w_strb_q);
            end else if (aw_addr_q == `SPG_ADDR_TIME) begin
                time_q <= spg_merge(time_q, w_data_q, w_strb_q);
            end else if (aw_addr_q == `SPG_ADDR_MODE) begin
                mode_q <= w_data_q[0];
            end else if (aw_addr_q == `SPG_ADDR_PERIOD) begin
                period_q <= wd_per;
            end else if (aw_addr_q == `SPG_ADDR_EDGE) begin
                edge_q <= w_data_q[0];
            end else if (aw_addr_q == `SPG_ADDR_TZONE) begin
                tz_q <= w_data_q[15:0];
            end
        end
    end

    assign cfg.start_date = date_q;
    assign cfg.start_time = time_q;
    assign cfg.rep_mode = mode_q;
    assign cfg.period = period_q;
    assign cfg.fall_edge = edge_q;
    assign cfg.tz_hour_mag = tz_q[12:8];
    assign cfg.tz_hour_neg = tz_q[15];
    assign cfg.tz_min_mag = tz_q[5:0];
    assign cfg.tz_min_neg = tz_q[7];
    // tz write is not a pulse setting, so it does not re-arm
    assign cfg.rearm = do_wr && aw_addr_q != `SPG_ADDR_TZONE;
    assign cfg.date_written = do_wr && aw_addr_q == `SPG_ADDR_DATE;
    assign cfg.period_written = do_wr && aw_addr_q == `SPG_ADDR_PERIOD;

    // ---------------------------------------------------------------
    // local time base
    // ---------------------------------------------------------------
    logic [16:0] local_sod;
    logic [1:0] day_adj;
    spg_local_secs u_local (
        .aclk(aclk),
        .aresetn(aresetn),
        .utc_sod(utc_sod_in),
        .cfg(cfg),
        .local_sod_q(local_sod),
        .day_adj_q(day_adj)
    );
    // date ordinal good enough for ordering: y*2048 + m*128 + d*4
    function automatic logic [22:0] spg_day_key(input logic [31:0] d);
        return {d[27:16], d[11:8], d[4:0], 2'b00};
    endfunction
    wire [22:0] now_key_utc = spg_day_key(utc_date_in);
    // day roll moves key by one step; month/year edges approximated
    wire [22:0] now_key = (day_adj == 2'h1) ? now_key_utc + 23'h000004 :
        (day_adj == 2'h2) ? now_key_utc - 23'h000004 : now_key_utc;
    wire [22:0] start_key = spg_day_key(date_q);
    wire [16:0] start_sod = 17'(time_q[20:16]) * 17'd3600
        + 17'(time_q[13:8]) * 17'd60 + 17'(time_q[5:0]);
    // local_sod is the second just beginning at the tick
    wire start_hit = now_key == start_key && local_sod == start_sod;
    wire start_past = now_key > start_key
        || (now_key == start_key && local_sod > start_sod);

    // ---------------------------------------------------------------
    // scheduler
    // ---------------------------------------------------------------
    spg_state_t state_q;
    logic [24:0] sec_cnt_q;
    logic fire;
    logic [$clog2(PULSE_CYC+1)-1:0] width_q;
    logic stale_q;
    always_comb begin
        fire = 1'b0;
        if (sec_tick && lock_s2_q) begin
            if (state_q == SPG_ARMED && start_hit) begin
                fire = 1'b1;
            end else if (state_q == SPG_RUN && sec_cnt_q == 25'h0000001) begin
                fire = 1'b1;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= SPG_IDLE;
            sec_cnt_q <= 25'h0000000;
            stale_q <= 1'b0;
        end else if (cfg.rearm) begin
            // interval edit after start has passed: wait for a new date
            if (cfg.period_written && start_past) begin
                stale_q <= 1'b1;
            end else if (cfg.date_written) begin
                stale_q <= 1'b0;
            end
            state_q <= (stale_q && !cfg.date_written) || (cfg.period_written
                && start_past) ? SPG_IDLE : SPG_ARMED;
            sec_cnt_q <= 25'h0000000;
        end else if (sec_tick) begin
            if (state_q == SPG_IDLE && !stale_q && lock_s2_q) begin
                state_q <= SPG_ARMED;
            end else if (state_q == SPG_ARMED && lock_s2_q && start_past) begin
                state_q <= SPG_DONE;
            end else if (fire) begin
                state_q <= mode_q ? SPG_RUN : SPG_DONE;
                sec_cnt_q <= period_q;
            end else if (state_q == SPG_RUN) begin
                sec_cnt_q <= sec_cnt_q - 25'h0000001;
            end
        end
    end
    // pulse shaping; fall_edge inverts so on-time edge is falling
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            width_q <= '0;
            pulse_out_q <= 1'b0;
        end else begin
            if (fire) begin
                width_q <= ($clog2(PULSE_CYC+1))'(PULSE_CYC);
            end else if (width_q != '0) begin
                width_q <= width_q - 1'b1;
            end
            pulse_out_q <= edge_q ^ (fire || width_q > 1);
        end
    end

    // ---------------------------------------------------------------
    // read channel
    // ---------------------------------------------------------------
    logic [31:0] rd_val;
    logic rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        rd_val = 32'h00000000;
        if (araddr[7:0] == `SPG_ADDR_DATE) begin
            rd_val = date_q;
        end else if (araddr[7:0] == `SPG_ADDR_TIME) begin
            rd_val = time_q;
        end else if (araddr[7:0] == `SPG_ADDR_MODE) begin
            rd_val = {31'h00000000, mode_q};
        end else if (araddr[7:0] == `SPG_ADDR_PERIOD) begin
            rd_val = {7'h00, period_q};
        end else if (araddr[7:0] == `SPG_ADDR_EDGE) begin
            rd_val = edge_q ? SPG_FALL_CODE : SPG_RISING_CODE;
        end else if (araddr[7:0] == `SPG_ADDR_TZONE) begin
            rd_val = {16'h0000, tz_q};
        end else if (araddr[7:0] == `SPG_ADDR_STATUS) begin
            rd_val = {26'h0000000, stale_q, lock_s2_q, 2'h0, 2'(state_q)};
        end else if (araddr[7:0] == `SPG_ADDR_NOW_DATE) begin
            rd_val = utc_date_in;
        end else if (araddr[7:0] == `SPG_ADDR_NOW_TIME) begin
            rd_val = {15'h0000, local_sod};
        end else begin
            rd_ok = 1'b0;
        end
    end
    assign arready = !rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= 2'h0;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= rd_val;
            rresp <= rd_ok ? 2'h0 : 2'h2;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    AST_SINGLE_DONE: assert property (@(posedge aclk) disable iff (!aresetn)
        fire && !mode_q && !cfg.rearm |=> state_q == SPG_DONE)
        else $error("single shot did not finish");
    AST_REARM: assert property (@(posedge aclk) disable iff (!aresetn)
        cfg.rearm && !cfg.period_written && !stale_q
        |=> state_q == SPG_ARMED)
        else $error("settings change did not re-arm");
    AST_STALE: assert property (@(posedge aclk) disable iff (!aresetn)
        stale_q && !cfg.date_written |-> !fire)
        else $error("pulse while stale");
    AST_PERIOD: assert property (@(posedge aclk) disable iff (!aresetn)
        fire && mode_q && !cfg.rearm |=> sec_cnt_q == $past(period_q))
        else $error("interval not loaded");
    AST_WIDTH: assert property (@(posedge aclk) disable iff (!aresetn)
        fire |=> (pulse_out_q != edge_q)[*2])
        else $error("pulse too short");
    AST_EDGE_CODE: assert property (@(posedge aclk) disable iff (!aresetn)
        arvalid && arready && araddr[7:0] == `SPG_ADDR_EDGE
        |=> rdata == ($past(edge_q) ? SPG_FALL_CODE : SPG_RISING_CODE))
        else $error("polarity code wrong");
    AST_NO_PAST: assert property (@(posedge aclk) disable iff (!aresetn)
        state_q == SPG_DONE && !cfg.rearm |=> !fire)
        else $error("pulse after done");
    AST_FIRST: assert property (@(posedge aclk) disable iff (!aresetn)
        fire && state_q == SPG_ARMED |-> start_hit)
        else $error("first pulse off start");
endmodule

// file: spg_params.svh
`ifndef SPG_PARAMS_SVH
`define SPG_PARAMS_SVH

`define SPG_ADDR_DATE 8'h00
`define SPG_ADDR_TIME 8'h04
`define SPG_ADDR_MODE 8'h08
`define SPG_ADDR_PERIOD 8'h0C
`define SPG_ADDR_EDGE 8'h10
`define SPG_ADDR_TZONE 8'h14
`define SPG_ADDR_STATUS 8'h18
`define SPG_ADDR_NOW_DATE 8'h1C
`define SPG_ADDR_NOW_TIME 8'h20

`define SPG_YEAR_MIN 12'd1994
`define SPG_YEAR_MAX 12'd3000
`define SPG_PERIOD_MIN 25'h0000001
`define SPG_PERIOD_MAX 25'h1E13380
`define SPG_HOUR_MAX 5'd23
`define SPG_MIN_MAX 6'd59
`define SPG_TZ_HOUR_LIM 5'd12
`define SPG_TZ_MIN_LIM 6'd59
`define SPG_RST_DATE 32'h07CA0101
`define SPG_RST_TIME 32'h00000000
`define SPG_RST_PERIOD 25'h0000001

`define SPG_CLK_HZ 125000000
`define SPG_PULSE_WIDTH_US 1000
`define SPG_PULSE_CYC ((`SPG_PULSE_WIDTH_US * (`SPG_CLK_HZ / 1000000)))
`endif

// file: spg_pkg.sv
package spg_pkg;
    typedef enum logic [1:0] {
        SPG_IDLE,
        SPG_ARMED,
        SPG_RUN,
        SPG_DONE
    } spg_state_t;

    // polarity readback codes, ascii-packed
    typedef enum logic [31:0] {
        SPG_RISING_CODE = 32'h00524953,
        SPG_FALL_CODE = 32'h46414C4C
    } spg_edge_code_t;
endpackage

// file: spg_cfg_if.sv
`timescale 1ns/10ps
interface spg_cfg_if;
    logic [31:0] start_date;
    logic [31:0] start_time;
    logic rep_mode;
    logic [24:0] period;
    logic fall_edge;
    logic [4:0] tz_hour_mag;
    logic tz_hour_neg;
    logic [5:0] tz_min_mag;
    logic tz_min_neg;
    logic rearm;
    logic date_written;
    logic period_written;
    modport src (
        output start_date, start_time, rep_mode, period, fall_edge,
        output tz_hour_mag, tz_hour_neg, tz_min_mag, tz_min_neg,
        output rearm, date_written, period_written
    );
    modport dst (
        input start_date, start_time, rep_mode, period, fall_edge,
        input tz_hour_mag, tz_hour_neg, tz_min_mag, tz_min_neg,
        input rearm, date_written, period_written
    );
endinterface

// file: spg_local_secs.sv
`timescale 1ns/10ps
`include "spg_params.svh"
// local seconds of day from utc seconds of day and the zone offset
module spg_local_secs
    import spg_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [16:0] utc_sod,
    spg_cfg_if.dst cfg,
    output logic [16:0] local_sod_q,
    output logic [1:0] day_adj_q
);
    localparam logic signed [18:0] DAY_S = 19'sd86400;
    logic signed [18:0] off;
    logic signed [18:0] sum;
    logic signed [18:0] hr_s;
    logic signed [18:0] mn_s;
    // hour and minute parts carry their own signs
    always_comb begin
        hr_s = 19'(cfg.tz_hour_mag) * 19'sd3600;
        mn_s = 19'(cfg.tz_min_mag) * 19'sd60;
        if (cfg.tz_hour_neg) begin
            hr_s = -hr_s;
        end
        if (cfg.tz_min_neg) begin
            mn_s = -mn_s;
        end
        off = hr_s + mn_s;
        sum = 19'(utc_sod) + off;
    end
    // day_adj: 0 same day, 1 next day, 2 previous day
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            local_sod_q <= 17'h00000;
            day_adj_q <= 2'h0;
        end else if (sum < 0) begin
            local_sod_q <= 17'(sum + DAY_S);
            day_adj_q <= 2'h2;
        end else if (sum >= DAY_S) begin
            local_sod_q <= 17'(sum - DAY_S);
            day_adj_q <= 2'h1;
        end else begin
            local_sod_q <= 17'(sum);
            day_adj_q <= 2'h0;
        end
    end
endmodule

// file: spg_pulse_sink.sv
`timescale 1ns/10ps
// ------------------------------------------------
// far-side equipment: counts on-time edges
// ------------------------------------------------
module spg_pulse_sink (
    input wire logic aclk,
    input wire logic pulse_in,
    input wire logic fall_sel,
    input wire logic clr,
    output logic [7:0] count_q,
    output logic [7:0] width_q
);
    logic prev_q;
    logic [7:0] run_q;

    // on-time edge leaves the idle level, idle equals fall_sel
    always_ff @(posedge aclk) begin
        prev_q <= pulse_in;
        if (clr) begin
            count_q <= 8'h00;
        end else if (pulse_in != prev_q && pulse_in == !fall_sel) begin
            count_q <= count_q + 8'h01;
        end
    end

    // width of the last active stretch, kept once it ends
    always_ff @(posedge aclk) begin
        if (pulse_in == !fall_sel) begin
            run_q <= run_q + 8'h01;
        end else begin
            run_q <= 8'h00;
        end
        if (pulse_in == fall_sel && run_q != 8'h00) begin
            width_q <= run_q;
        end
    end
endmodule

// file: scheduled_pulse_generator_tb.sv
`timescale 1ns/10ps
`include "spg_params.svh"
module scheduled_pulse_generator_tb
    import spg_pkg::*;
;
    logic aclk, aresetn, pps_in, locked_in, clr, fall_sel, pulse_out_q;
    logic [31:0] utc_date_in, awaddr, wdata, araddr, rdata;
    logic [16:0] utc_sod_in;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp;
    logic [7:0] count_q, width_q;
    int n_mismatch, checks_done, cyc, sod;

    // ------------------------------------------------
    // design and far side
    // ------------------------------------------------
    spg_pulse_gen #(.PULSE_CYC(4)) u_spg_pulse_gen (
        .aclk(aclk), .aresetn(aresetn), .pps_in(pps_in),
        .locked_in(locked_in), .utc_date_in(utc_date_in),
        .utc_sod_in(utc_sod_in), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready),
        .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .pulse_out_q(pulse_out_q));
    spg_pulse_sink u_spg_pulse_sink (.aclk(aclk), .pulse_in(pulse_out_q),
        .fall_sel(fall_sel), .clr(clr), .count_q(count_q),
        .width_q(width_q));

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    task automatic print_verdict();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ceiling well above the ~1500 cycles the run needs
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_mismatch = n_mismatch + 1;
            print_verdict();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        logic done;
        done = 1'b0;
        awaddr <= {24'h000000, a};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                done = 1'b1;
                bready <= 1'b0;
                chk("bresp", {30'h0, er}, {30'h0, bresp});
            end
        end
        // one edge between transfers, so bready is not set twice at once
        @(posedge aclk);
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
        logic done;
        done = 1'b0;
        araddr <= {24'h000000, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                done = 1'b1;
                rready <= 1'b0;
                chk("rdata", ed, rdata);
                chk("rresp", {30'h0, er}, {30'h0, rresp});
            end
        end
        @(posedge aclk);
    endtask

    function automatic logic [31:0] tod(input int s);
        tod = 32'((s / 3600) << 16 | ((s / 60) % 60) << 8 | s % 60);
    endfunction

    // one second of the time base: new sod, then the pps edge
    task automatic tick();
        sod = sod + 1;
        utc_sod_in <= 17'(sod);
        repeat (2) @(posedge aclk);
        pps_in <= 1'b1;
        repeat (20) @(posedge aclk);
        pps_in <= 1'b0;
        repeat (20) @(posedge aclk);
    endtask

    task automatic cfg(input logic rep, input int per, input logic fall,
                       input int st);
        axi_wr(`SPG_ADDR_MODE, {31'h0, rep}, 2'h0);
        axi_wr(`SPG_ADDR_PERIOD, 32'(per), 2'h0);
        axi_wr(`SPG_ADDR_EDGE, {31'h0, fall}, 2'h0);
        axi_wr(`SPG_ADDR_TIME, tod(st), 2'h0);
        axi_wr(`SPG_ADDR_DATE, 32'h07E80101, 2'h0);
        fall_sel <= fall;
        repeat (3) @(posedge aclk);
        clr <= 1'b1;
        @(posedge aclk);
        clr <= 1'b0;
    endtask

    // st far ahead means no pulse is expected
    task automatic run(input int n, input int st, input logic rep,
                       input int per);
        int e;
        for (int i = 0; i < n; i++) begin
            tick();
            e = (sod < st) ? 0 : (rep ? (sod - st) / per + 1 : 1);
            chk("pulses", 32'(e), {24'h0, count_q});
            if (e > 0) chk("width", 32'h4, {24'h0, width_q});
        end
    endtask

    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic t_reset();
        axi_rd(`SPG_ADDR_DATE, `SPG_RST_DATE, 2'h0);
        axi_rd(`SPG_ADDR_TIME, 32'h0, 2'h0);
        axi_rd(`SPG_ADDR_MODE, 32'h0, 2'h0);
        axi_rd(`SPG_ADDR_PERIOD, 32'h1, 2'h0);
        axi_rd(`SPG_ADDR_EDGE, SPG_RISING_CODE, 2'h0);
        axi_rd(8'h40, 32'h0, 2'h2);
    endtask

    task automatic t_range();
        axi_wr(`SPG_ADDR_PERIOD, 32'h0, 2'h2);
        axi_wr(`SPG_ADDR_PERIOD, 32'h01E13381, 2'h2);
        axi_wr(`SPG_ADDR_PERIOD, 32'h01E13380, 2'h0);
        axi_rd(`SPG_ADDR_PERIOD, 32'h01E13380, 2'h0);
        axi_wr(`SPG_ADDR_DATE, 32'h07C90101, 2'h2);
        axi_wr(`SPG_ADDR_DATE, 32'h0BB90101, 2'h2);
        axi_wr(`SPG_ADDR_DATE, 32'h07CA0D01, 2'h2);
        axi_wr(`SPG_ADDR_TIME, 32'h00180000, 2'h2);
        axi_wr(`SPG_ADDR_TIME, 32'h00003C00, 2'h2);
        axi_wr(`SPG_ADDR_TIME, 32'h00173B3B, 2'h0);
        axi_rd(`SPG_ADDR_DATE, `SPG_RST_DATE, 2'h0);
    endtask

    task automatic t_nolock();
        cfg(1'b0, 1, 1'b0, sod + 2);
        run(4, 999999, 1'b0, 1);
        locked_in <= 1'b1;
    endtask

    task automatic t_single();
        int st;
        st = sod + 3;
        cfg(1'b0, 3, 1'b0, st);
        axi_rd(`SPG_ADDR_MODE, 32'h0, 2'h0);
        run(8, st, 1'b0, 3);
    endtask

    task automatic t_repeat();
        int st;
        st = sod + 2;
        cfg(1'b1, 2, 1'b1, st);
        axi_rd(`SPG_ADDR_MODE, 32'h1, 2'h0);
        axi_rd(`SPG_ADDR_EDGE, SPG_FALL_CODE, 2'h0);
        chk("idle", 32'h1, {31'h0, pulse_out_q});
        run(7, st, 1'b1, 2);
    endtask

    task automatic t_past();
        axi_wr(`SPG_ADDR_PERIOD, 32'h1, 2'h0);
        clr <= 1'b1;
        @(posedge aclk);
        clr <= 1'b0;
        run(4, 999999, 1'b1, 1);
        axi_rd(`SPG_ADDR_STATUS, 32'h00000030, 2'h0);
        cfg(1'b1, 1, 1'b0, sod - 3);
        run(4, 999999, 1'b1, 1);
    endtask

    // zone +1 h; the start is written in local time, pulses fall in utc
    task automatic t_zone();
        int st;
        st = sod + 2;
        axi_wr(`SPG_ADDR_TZONE, 32'h00000100, 2'h0);
        axi_wr(`SPG_ADDR_TZONE, 32'h00000D00, 2'h2);
        axi_rd(`SPG_ADDR_TZONE, 32'h00000100, 2'h0);
        cfg(1'b0, 1, 1'b0, st + 3600);
        axi_rd(`SPG_ADDR_NOW_TIME, 32'(sod + 3600), 2'h0);
        run(4, st, 1'b0, 1);
    endtask

    initial begin
        aresetn = 1'b0;
        pps_in = 1'b0;
        locked_in = 1'b0;
        clr = 1'b1;
        fall_sel = 1'b0;
        utc_date_in = 32'h07E80101;
        utc_sod_in = 17'h00000;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        awaddr = 32'h0;
        wdata = 32'h0;
        araddr = 32'h0;
        n_mismatch = 0;
        checks_done = 0;
        cyc = 0;
        sod = 0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        clr <= 1'b0;
        @(posedge aclk);
        t_reset();
        t_range();
        t_nolock();
        t_single();
        t_repeat();
        t_past();
        t_zone();
        print_verdict();
    end
endmodule
